//--- decode_front_map.vh
/*
 Constants for the instruction decode front end: window, queue and
 selection sizes, and decode class codes.
 Assumes inclusion by bare name from the design file.
*/
`ifndef DECODE_FRONT_MAP_VH
`define DECODE_FRONT_MAP_VH
`define WIN_BYTES 16
`define WIN_ALIGN_BITS 4
`define QUEUE_BYTES 24
`define QUEUE_CNT_W 5
`define MAX_SELECT 3
`define MAX_ROM_SELECT 1
`define CLASS_HARD 2'h0
`define CLASS_ROM 2'h1
`define CLASS_FP_INT 2'h2
`define CLASS_RMW 2'h3
`define ROM_ADDR_W 4
`define FP_INT_OPS 2
`endif

//--- instruction_decode_front_end.v
/*
 Instruction fetch window merge, byte queue and decode path selection.
 Assumes an instruction cache that returns a 16-byte window any number of cycles
 after a taken request, a length/class predecoder that is combinational
 on the queue head, and schedulers with a ready level. One clock.
 Selection is combinational on the queue head; every output that carries
 data comes from a flip-flop, and the fetch request is combinational.
*/
`timescale 1ns/1ns
`include "decode_front_map.vh"
module instruction_decode_front_end (
   input wire i_sys_clk,
   input wire i_sys_rst,
   input wire [31:0] i_redirect_addr,
   input wire i_redirect,
   output wire o_fetch_req,
   output reg [31:0] o_fetch_addr,
   input wire i_fetch_valid,
   input wire [127:0] i_fetch_data,
   output wire [191:0] o_queue_bytes,
   output wire [4:0] o_queue_count,
   input wire [11:0] i_insn_len,
   input wire [5:0] i_insn_class,
   input wire [11:0] i_rom_len,
   input wire i_sched_ready,
   output reg [2:0] o_hard_valid,
   output reg [95:0] o_hard_bytes,
   output reg o_rom_valid,
   output reg [3:0] o_rom_addr,
   output reg [1:0] o_rom_class,
   output reg o_rmw_single_station,
   output reg o_rmw_single_agu
);
   reg [191:0] queue;
   reg [4:0] count;
   reg pending;
   reg [3:0] rom_left;
   reg [3:0] next_rom_left;
   reg [2:0] sel_n;
   reg [4:0] sel_bytes;
   reg sel_rom;
   reg [4:0] acc;
   reg stop;
   integer k;
   integer j;
   wire [3:0] slot_len [0:2];
   wire [1:0] slot_class [0:2];
   wire [2:0] slot_rom;
   wire [2:0] slot_rmw;
   wire [4:0] remain;
   wire [4:0] room;
   wire [191:0] shifted;
   wire [191:0] merged;
   wire can_fetch;
   genvar g;

   // Sized copies of the shared sizes
   localparam [4:0] QUEUE_SIZE = `QUEUE_BYTES;
   localparam [4:0] WIN_SIZE = `WIN_BYTES;
   localparam [31:0] WIN_STEP = `WIN_BYTES;

   // Unpack one predecoder slot per selection position
   generate
      for (g = 0; g < `MAX_SELECT; g = g + 1) begin : slot
         assign slot_len[g] = i_insn_len[g*4 +: 4];
         assign slot_class[g] = i_insn_class[g*2 +: 2];
         assign slot_rom[g] = (slot_class[g] == `CLASS_ROM) ||
            (slot_class[g] == `CLASS_FP_INT);
         assign slot_rmw[g] = slot_class[g] == `CLASS_RMW;
      end
   endgenerate

   assign o_queue_bytes = queue;
   assign o_queue_count = count;
   // Bytes left once this cycle's selection leaves the head
   assign remain = count - sel_bytes;
   assign room = QUEUE_SIZE - remain;
   assign shifted = queue >> {sel_bytes, 3'h0};
   assign merged = shifted | ({64'h0, i_fetch_data} << {remain, 3'h0});
   assign can_fetch = !pending && (room >= WIN_SIZE) && !i_redirect;
   assign o_fetch_req = can_fetch;

   // Selection over queue head
   always @* begin
      sel_n = 3'h0;
      sel_bytes = 5'h00;
      sel_rom = 1'b0;
      acc = 5'h00;
      stop = (rom_left != 4'h0) || !i_sched_ready;
      for (k = 0; k < `MAX_SELECT; k = k + 1) begin
         if (!stop) begin
            // Unknown length or a partial instruction ends the group
            if (slot_len[k] == 4'h0) begin
               stop = 1'b1;
            end else if ({1'b0, acc} + {2'b00, slot_len[k]} > {1'b0, count}) begin
               stop = 1'b1;
            end else if (slot_rom[k]) begin
               // rom only alone
               // A rom instruction behind hardwired ones waits for slot 0
               if (k == 0) begin
                  sel_rom = 1'b1;
                  sel_n = 3'h1;
                  acc = {1'b0, slot_len[k]};
               end
               stop = 1'b1;
            end else begin
               sel_n = sel_n + 3'h1;
               acc = acc + {1'b0, slot_len[k]};
            end
         end
      end
      sel_bytes = acc;
   end

   // Rom operations still owed after this edge
   always @* begin
      next_rom_left = rom_left;
      if (rom_left != 4'h0 && i_sched_ready) begin
         next_rom_left = rom_left - 4'h1;
      end else if (sel_rom) begin
         if (i_insn_class[1:0] == `CLASS_FP_INT) begin
            next_rom_left = 4'h0;
         end else begin
            next_rom_left = (i_rom_len[3:0] > 4'h1) ? i_rom_len[3:0] - 4'h1 : 4'h0;
         end
      end
   end

   // Fetch address, request tracking and byte queue
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         queue <= 192'h0;
         count <= 5'h00;
         pending <= 1'b0;
         o_fetch_addr <= 32'h00000000;
      end else if (i_redirect) begin
         // Flush drops the queue and any window still in flight
         queue <= 192'h0;
         count <= 5'h00;
         pending <= 1'b0;
         o_fetch_addr <= {i_redirect_addr[31:`WIN_ALIGN_BITS], 4'h0};
      end else begin
         if (pending && i_fetch_valid) begin
            queue <= merged;
            count <= remain + WIN_SIZE;
            pending <= 1'b0;
            o_fetch_addr <= o_fetch_addr + WIN_STEP;
         end else begin
            queue <= shifted;
            count <= remain;
            if (can_fetch) begin
               pending <= 1'b1;
            end
         end
      end
   end

   // Rom sequence counter
   always @(posedge i_sys_clk) begin
      if (i_sys_rst || i_redirect) begin
         rom_left <= 4'h0;
      end else begin
         rom_left <= next_rom_left;
      end
   end

   // Issue outputs, registered on the selecting edge
   always @(posedge i_sys_clk) begin
      if (i_sys_rst || i_redirect) begin
         o_hard_valid <= 3'h0;
         o_hard_bytes <= 96'h0;
         o_rom_valid <= 1'b0;
         o_rom_addr <= 4'h0;
         o_rom_class <= 2'h0;
         o_rmw_single_station <= 1'b0;
         o_rmw_single_agu <= 1'b0;
      end else begin
         o_hard_valid <= 3'h0;
         o_hard_bytes <= queue[95:0];
         o_rom_valid <= 1'b0;
         o_rmw_single_station <= 1'b0;
         o_rmw_single_agu <= 1'b0;
         // Sequence steps only while the schedulers take them
         if (rom_left != 4'h0) begin
            if (i_sched_ready) begin
               o_rom_valid <= 1'b1;
               o_rom_addr <= o_rom_addr + 4'h1;
            end
         end else if (sel_rom) begin
            o_rom_valid <= 1'b1;
            o_rom_addr <= 4'h0;
            o_rom_class <= slot_class[0];
         end else begin
            for (j = 0; j < `MAX_SELECT; j = j + 1) begin
               if (j < sel_n) begin
                  o_hard_valid[j] <= 1'b1;
                  if (slot_rmw[j]) begin
                     o_rmw_single_station <= 1'b1;
                     o_rmw_single_agu <= 1'b1;
                  end
               end
            end
         end
      end
   end
endmodule // instruction_decode_front_end

//--- ide_props.sv
/* Port checker for the decode front end; bound to the design top. */
`timescale 1ns/1ns
module ide_props (
   input wire i_sys_clk,
   input wire i_sys_rst,
   input wire i_sched_ready,
   input wire o_fetch_req,
   input wire [31:0] o_fetch_addr,
   input wire [4:0] o_queue_count,
   input wire [2:0] o_hard_valid,
   input wire o_rom_valid,
   input wire [3:0] o_rom_addr,
   input wire [1:0] o_rom_class,
   input wire o_rmw_single_station,
   input wire o_rmw_single_agu
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   fetch_align_a: assert property (o_fetch_req |-> o_fetch_addr[3:0] == 4'h0)
      else $error("fetch misaligned");
   queue_cap_a: assert property (o_queue_count <= 5'h18)
      else $error("queue overfull");
   hard_slots_a: assert property (o_hard_valid inside {3'h0, 3'h1, 3'h3, 3'h7})
      else $error("hard slots");
   path_mix_a: assert property (!(o_rom_valid && o_hard_valid != 3'h0))
      else $error("paths mixed");
   rom_step_a: assert property (o_rom_valid && $past(o_rom_valid) && o_rom_addr != 4'h0
      |-> o_rom_addr == $past(o_rom_addr) + 4'h1 && $stable(o_rom_class)) else $error("rom step");
   fp_int_a: assert property (o_rom_valid && o_rom_class == 2'h2 |-> o_rom_addr == 4'h0)
      else $error("fp int op");
   rmw_one_a: assert property (o_rmw_single_station |-> o_rmw_single_agu && o_hard_valid)
      else $error("rmw path");
   ready_gate_a: assert property (!$past(i_sched_ready) |-> o_hard_valid == 3'h0)
      else $error("select unready");
endmodule // ide_props
bind instruction_decode_front_end ide_props chk (.*);

//--- icache_model.sv
/* Cache model: answers one fetch after 1 to 4 cycles; a redirect drops it. */
`timescale 1ns/1ns
module icache_model (
   input wire i_sys_clk,
   input wire i_redirect,
   input wire i_req,
   input wire [31:0] i_addr,
   input wire [1:0] i_delay,
   output reg o_valid = 1'b0,
   output reg [127:0] o_data = 128'h0
);
   reg [2:0] wait_cnt = 3'h0;
   wire fire = !i_redirect && wait_cnt == 3'h1;
   function [127:0] window(input [7:0] base);
      integer b;
      begin
         window = 128'h0;
         for (b = 0; b < 16; b = b + 1) begin
            window[8*b +: 8] = base + b[7:0];
         end
      end
   endfunction
   always @(posedge i_sys_clk) begin
      o_valid <= fire;
      // aligned window; idle bus shows the inverse
      o_data <= fire ? window(i_addr[7:0]) : ~o_data;
      if (i_redirect) wait_cnt <= 3'h0;
      else if (wait_cnt == 3'h1) wait_cnt <= 3'h0;
      else if (wait_cnt != 3'h0) wait_cnt <= wait_cnt - 3'h1;
      else if (i_req) wait_cnt <= {1'b0, i_delay} + 3'h1;
   end
endmodule // icache_model

//--- instruction_decode_front_end_test.sv
/* Random bench for the decode front end; needs ide_props and icache_model. */
`timescale 1ns/1ns
module instruction_decode_front_end_test;
   reg i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_redirect = 1'b0, i_sched_ready = 1'b0;
   reg [31:0] i_redirect_addr = 32'h0, seed = 32'h86F0;
   reg [11:0] i_insn_len = 12'h0, i_rom_len = 12'h1;
   reg [5:0] i_insn_class = 6'h0;
   reg [95:0] prev_q = 96'h0;
   reg [1:0] delay = 2'h0;
   reg [3:0] rl = 4'h0, p = 4'h0;
   reg [2:0] want_hard = 3'h0;
   reg want_rom = 1'b0;
   wire o_fetch_req, i_fetch_valid, o_rom_valid, o_rmw_single_station, o_rmw_single_agu;
   wire [31:0] o_fetch_addr;
   wire [127:0] i_fetch_data;
   wire [191:0] o_queue_bytes;
   wire [95:0] o_hard_bytes;
   wire [4:0] o_queue_count;
   wire [3:0] o_rom_addr;
   wire [2:0] o_hard_valid;
   wire [1:0] o_rom_class;
   integer errors = 0, n_checks = 0, i;
   instruction_decode_front_end uut (.*);
   icache_model cache (.i_sys_clk, .i_redirect, .i_req(o_fetch_req), .i_addr(o_fetch_addr),
      .i_delay(delay), .o_valid(i_fetch_valid), .o_data(i_fetch_data));
   always #4 i_sys_clk = ~i_sys_clk;
   function [31:0] xs(input [31:0] s);
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   // Selection a cycle takes: bit 3 rom pick, low bits hardwired count
   function [3:0] pick(input [11:0] len, input [5:0] cls, input [4:0] cnt);
      integer s, used;
      reg stop;
      begin
         pick = 4'h0;
         used = 0;
         stop = 1'b0;
         for (s = 0; s < 3; s = s + 1) begin
            if (stop || len[4*s +: 4] == 4'h0 || used + len[4*s +: 4] > cnt) begin
               stop = 1'b1;
            end else if (cls[2*s +: 2] == 2'h1 || cls[2*s +: 2] == 2'h2) begin
               if (s == 0) pick = 4'h8;
               stop = 1'b1;
            end else begin
               pick = pick + 4'h1;
               used = used + len[4*s +: 4];
            end
         end
      end
   endfunction
   task check(input [191:0] seen, input [191:0] want);
      n_checks = n_checks + 1;
      if (seen !== want) begin
         errors = errors + 1;
         $display("MISMATCH %0t value differs", $time);
      end
   endtask
   task test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100000 errors = errors + 1;
      test_done;
   end
   initial begin
      repeat (8) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_sys_clk) i_redirect <= 1'b1;
      i_redirect_addr <= 32'h1234567B;
      @(posedge i_sys_clk) i_redirect <= 1'b0;
      #1 check(o_fetch_addr, 32'h12345670);
      for (i = 0; i < 50 && !i_fetch_valid; i = i + 1) @(posedge i_sys_clk) #1;
      @(posedge i_sys_clk) #1 check(o_queue_count, 5'h10);
      for (i = 0; i < 16; i = i + 1) check(o_queue_bytes[8*i +: 8], 8'h70 + i);
      for (i = 0; i < 3000; i = i + 1) begin
         @(posedge i_sys_clk) seed = xs(seed);
         i_sched_ready <= seed[3:2] != 2'h0;
         i_insn_len <= seed[15:4];
         i_insn_class <= seed[21:16];
         i_rom_len <= {10'h0, seed[23:22]} + 12'h1;
         i_redirect <= seed[31:25] == 7'h0;
         i_redirect_addr <= xs(seed);
         delay <= seed[27:26];
         #1 if (o_hard_valid !== 3'h0) check(o_hard_bytes, prev_q);
         check(o_hard_valid, want_hard);
         check(o_rom_valid, want_rom);
         prev_q = o_queue_bytes[95:0];
         want_hard = 3'h0;
         want_rom = 1'b0;
         if (i_redirect) begin
            rl = 4'h0;
         end else if (rl != 4'h0) begin
            want_rom = i_sched_ready;
            rl = rl - {3'h0, i_sched_ready};
         end else if (i_sched_ready) begin
            p = pick(i_insn_len, i_insn_class, o_queue_count);
            want_rom = p[3];
            want_hard = (3'h1 << p[1:0]) - 3'h1;
            if (p[3] && i_insn_class[1:0] == 2'h1 && i_rom_len[3:0] > 4'h1) begin
               rl = i_rom_len[3:0] - 4'h1;
            end
         end
      end
      test_done;
   end
endmodule // instruction_decode_front_end_test
